// ==== hdl/bcs_cycle_decode.sv ====
`timescale 1ns/1ps
`include "bcs_defs.svh"

module bcs_cycle_decode (
  input wire bcs_pkg::bcs_cycle_t cycle_type_i,
  output logic [2:0] status_o,
  output logic read_act_o,
  output logic write_act_o,
  output logic ack_act_o
);

  // status code for each cycle kind, and its active strobe; the two idle kinds drive none
  always_comb begin
    status_o = `BCS_STAT_BI_ACK;
    read_act_o = 1'b0;
    write_act_o = 1'b0;
    ack_act_o = 1'b0;
    unique case (cycle_type_i)
      bcs_pkg::OPCODE_FETCH_CYCLE: begin
        status_o = `BCS_STAT_OF; // R7
        read_act_o = 1'b1;
      end
      bcs_pkg::MEMORY_READ_CYCLE: begin
        status_o = `BCS_STAT_MR; // R8
        read_act_o = 1'b1;
      end
      bcs_pkg::MEMORY_WRITE_CYCLE: begin
        status_o = `BCS_STAT_MW; // R9
        write_act_o = 1'b1;
      end
      bcs_pkg::PORT_READ_CYCLE: begin
        status_o = `BCS_STAT_IOR; // R10
        read_act_o = 1'b1;
      end
      bcs_pkg::PORT_WRITE_CYCLE: begin
        status_o = `BCS_STAT_IOW; // R11
        write_act_o = 1'b1;
      end
      bcs_pkg::INTERRUPT_ACK_CYCLE: begin
        status_o = `BCS_STAT_INA; // R12
        ack_act_o = 1'b1;
      end
      bcs_pkg::BUS_IDLE_CYCLE_DAD: begin
        status_o = `BCS_STAT_BI_DAD; // R13
      end
      bcs_pkg::BUS_IDLE_CYCLE_ACK: begin
        status_o = `BCS_STAT_BI_ACK; // R13
      end
    endcase
  end

endmodule

// ==== hdl/bcs_defs.svh ====
// Behaviour
// R1 - low address shares data bus, latch strobe
// R2 - low address in T1, data afterwards
// R3 - port address on upper and lower lines
// R4 - cycle status valid from T1 onward
// R5 - read/write strobes only during transfer
// R6 - three T states, fetch four/six, waits
// R7 - opcode fetch: mem, status 11, read
// R8 - memory read: mem, status 10, read
// R9 - memory write: mem, status 01, write
// R10 - port read: io, status 10, read
// R11 - port write: io, status 01, write
// R12 - interrupt acknowledge: io, status 11, ack
// R13 - idle cycles: strobes high, fixed status
// R14 - halt: float select/strobes, status 00
// R15 - latch strobe T1 only, not double-add
// R16 - T4-T6: status 11, bus floats
// R17 - reset: float bus and strobes
// R18 - hold: float bus and strobes
// R19 - power-down by halt or hold
// R20 - halt power-down ends on interrupt/reset
// R21 - hold power-down ends on release/reset
// R22 - interrupts ignored while holding
// R23 - halt also sets hold status; code keeps hold_ack_o low in halt, and halted_o stays set through a hold
`ifndef BCS_DEFS_SVH
`define BCS_DEFS_SVH

// select, status one, status zero per cycle kind
`define BCS_STAT_OF 3'h3
`define BCS_STAT_MR 3'h2
`define BCS_STAT_MW 3'h1
`define BCS_STAT_IOR 3'h6
`define BCS_STAT_IOW 3'h5
`define BCS_STAT_INA 3'h7
`define BCS_STAT_BI_DAD 3'h2
`define BCS_STAT_BI_ACK 3'h7

`define BCS_LATE_STATUS 2'h3
`define BCS_HALT_STATUS 2'h0
`define BCS_SEL_IO 1'b1
`define BCS_SEL_MEM 1'b0
`define BCS_STROBE_OFF 1'b1

`define BCS_RST_STATUS 2'h0
`define BCS_RST_SEL 1'b0
`define BCS_RST_BYTE 8'h00
`define BCS_RST_ADDR 16'h0000

`endif

// ==== hdl/bcs_pkg.sv ====
package bcs_pkg;

  // machine cycle kinds requested by the core
  typedef enum logic [2:0] {
    OPCODE_FETCH_CYCLE,
    MEMORY_READ_CYCLE,
    MEMORY_WRITE_CYCLE,
    PORT_READ_CYCLE,
    PORT_WRITE_CYCLE,
    INTERRUPT_ACK_CYCLE,
    BUS_IDLE_CYCLE_DAD,
    BUS_IDLE_CYCLE_ACK
  } bcs_cycle_t;

  // machine states of the sequencer
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_TWAIT,
    ST_T3,
    ST_T4,
    ST_T5,
    ST_T6,
    ST_HALT,
    ST_HOLD
  } bcs_tstate_t;

endpackage

// ==== hdl/bcs_sequencer.sv ====
`timescale 1ns/1ps
`include "bcs_defs.svh"

module bcs_sequencer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cycle_req_i,
  input wire bcs_pkg::bcs_cycle_t cycle_type_i,
  input wire logic [15:0] cycle_addr_i,
  input wire logic [7:0] cycle_wdata_i,
  input wire logic fetch_six_i,
  input wire logic ale_suppress_i,
  input wire logic halt_req_i,
  input wire logic ready_i,
  input wire logic hold_i,
  input wire logic nonmaskable_interrupt_i,
  input wire logic edge_restart_interrupt_i,
  input wire logic level_restart_interrupt_b_i,
  input wire logic level_restart_interrupt_a_i,
  input wire logic general_interrupt_request_i,
  input wire logic [7:0] low_address_data_bus_i,
  output logic [7:0] low_address_data_bus_o,
  output logic low_address_data_bus_oe_o,
  output logic [7:0] upper_address_lines_o,
  output logic upper_address_lines_oe_o,
  output logic io_or_mem_select_o,
  output logic io_or_mem_select_oe_o,
  output logic cycle_status_bit_one_o,
  output logic cycle_status_bit_zero_o,
  output logic read_strobe_n_o,
  output logic read_strobe_oe_o,
  output logic write_strobe_n_o,
  output logic write_strobe_oe_o,
  output logic interrupt_ack_strobe_n_o,
  output logic address_latch_strobe_o,
  output logic cycle_taken_o,
  output logic read_data_valid_o,
  output logic [7:0] read_data_o,
  output logic hold_ack_o,
  output logic halted_o,
  output logic power_down_o,
  output logic halt_wake_o
);

  bcs_pkg::bcs_tstate_t state;
  bcs_pkg::bcs_tstate_t next_state;
  bcs_pkg::bcs_cycle_t cur_type;
  logic [15:0] cur_addr;
  logic [7:0] cur_wdata;
  logic cur_six;
  logic cur_noale;
  logic cur_reads;
  logic halted;
  logic edge_prev;

  // where the current cycle may end
  wire is_fetch = (cur_type == bcs_pkg::OPCODE_FETCH_CYCLE);
  wire last_t = (state == bcs_pkg::ST_T3 && !is_fetch) ||
                (state == bcs_pkg::ST_T4 && !cur_six) ||
                (state == bcs_pkg::ST_T6); // R6
  wire boundary = (state == bcs_pkg::ST_IDLE) || last_t;

  // requests are taken only between machine cycles; hold wins, then halt
  wire take_hold = boundary && hold_i; // R19
  wire take_halt = boundary && !hold_i && halt_req_i; // R19
  wire take_cycle = boundary && !hold_i && !halt_req_i && cycle_req_i;

  // any interrupt input ends a halt; only looked at in the halt state
  wire edge_seen = edge_restart_interrupt_i && !edge_prev;
  wire wake = nonmaskable_interrupt_i || edge_seen || level_restart_interrupt_b_i ||
              level_restart_interrupt_a_i || general_interrupt_request_i; // R20
  wire halt_leave = (state == bcs_pkg::ST_HALT) && !hold_i && wake; // R20

  // sequencing of T states
  always_comb begin
    next_state = state;
    if (take_hold) begin
      next_state = bcs_pkg::ST_HOLD;
    end else if (take_halt) begin
      next_state = bcs_pkg::ST_HALT;
    end else if (take_cycle) begin
      next_state = bcs_pkg::ST_T1;
    end else if (boundary) begin
      next_state = bcs_pkg::ST_IDLE;
    end else begin
      unique case (state)
        bcs_pkg::ST_T1: begin
          next_state = bcs_pkg::ST_T2;
        end
        bcs_pkg::ST_T2, bcs_pkg::ST_TWAIT: begin
          next_state = ready_i ? bcs_pkg::ST_T3 : bcs_pkg::ST_TWAIT; // R6
        end
        bcs_pkg::ST_T3: begin
          next_state = bcs_pkg::ST_T4; // R6
        end
        bcs_pkg::ST_T4: begin
          next_state = bcs_pkg::ST_T5; // R6
        end
        bcs_pkg::ST_T5: begin
          next_state = bcs_pkg::ST_T6;
        end
        bcs_pkg::ST_HOLD: begin
          if (!hold_i) begin
            next_state = halted ? bcs_pkg::ST_HALT : bcs_pkg::ST_IDLE; // R21 R23
          end
        end
        bcs_pkg::ST_HALT: begin
          if (hold_i) begin
            next_state = bcs_pkg::ST_HOLD; // R23
          end else if (wake) begin
            next_state = bcs_pkg::ST_IDLE; // R20
          end
        end
        default: begin
          next_state = bcs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // cycle information as seen in the next state
  wire bcs_pkg::bcs_cycle_t nx_type = take_cycle ? cycle_type_i : cur_type;
  wire [15:0] nx_addr = take_cycle ? cycle_addr_i : cur_addr;
  wire [7:0] nx_wdata = take_cycle ? cycle_wdata_i : cur_wdata;
  wire nx_noale = take_cycle ? ale_suppress_i : cur_noale;
  wire nx_port = (nx_type == bcs_pkg::PORT_READ_CYCLE) ||
                 (nx_type == bcs_pkg::PORT_WRITE_CYCLE);
  wire nx_ack = (nx_type == bcs_pkg::INTERRUPT_ACK_CYCLE);

  wire [2:0] dec_status;
  wire dec_read;
  wire dec_write;
  wire dec_ack;

  bcs_cycle_decode u_decode (
    .cycle_type_i(nx_type),
    .status_o(dec_status),
    .read_act_o(dec_read),
    .write_act_o(dec_write),
    .ack_act_o(dec_ack)
  );

  // state groups of the next state
  wire in_t1 = (next_state == bcs_pkg::ST_T1);
  wire in_xfer = (next_state == bcs_pkg::ST_T2) || (next_state == bcs_pkg::ST_TWAIT) ||
                 (next_state == bcs_pkg::ST_T3);
  wire in_late = (next_state == bcs_pkg::ST_T4) || (next_state == bcs_pkg::ST_T5) ||
                 (next_state == bcs_pkg::ST_T6);
  wire in_halt = (next_state == bcs_pkg::ST_HALT);
  wire in_hold = (next_state == bcs_pkg::ST_HOLD);
  wire in_float = in_halt || in_hold;

  // status and select: from T1 through T3, fixed in T4-T6 and halt
  wire next_sel = (in_t1 || in_xfer) ? dec_status[2] :
                  in_late ? (nx_ack ? `BCS_SEL_IO : `BCS_SEL_MEM) :
                  io_or_mem_select_o; // R4 R16
  wire [1:0] next_stat = (in_t1 || in_xfer) ? dec_status[1:0] :
                         in_late ? `BCS_LATE_STATUS :
                         in_halt ? `BCS_HALT_STATUS :
                         {cycle_status_bit_one_o, cycle_status_bit_zero_o}; // R4 R14 R16

  // address lines: port address copied onto both halves
  wire [7:0] next_upper = in_t1 ? (nx_port ? nx_addr[7:0] : nx_addr[15:8]) :
                          upper_address_lines_o; // R3
  wire [7:0] next_low = in_t1 ? nx_addr[7:0] : nx_wdata; // R1 R2
  wire next_low_oe = in_t1 || (in_xfer && dec_write); // R2 R16

  // command strobes only while data moves
  wire next_rd_n = !(in_xfer && dec_read); // R5
  wire next_wr_n = !(in_xfer && dec_write); // R5
  wire next_ack_n = !(in_xfer && dec_ack); // R12
  wire next_ale = in_t1 && !nx_noale; // R15
  wire next_halted = (halted && !halt_leave) || take_halt; // R23

  // sequencer state and held cycle information
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= bcs_pkg::ST_IDLE;
      cur_type <= bcs_pkg::BUS_IDLE_CYCLE_ACK;
      cur_addr <= `BCS_RST_ADDR;
      cur_wdata <= `BCS_RST_BYTE;
      cur_six <= 1'b0;
      cur_noale <= 1'b0;
      cur_reads <= 1'b0;
      halted <= 1'b0; // R20 R21
      edge_prev <= 1'b0;
    end else begin
      state <= next_state;
      halted <= next_halted;
      edge_prev <= edge_restart_interrupt_i;
      if (take_cycle) begin
        cur_type <= cycle_type_i;
        cur_addr <= cycle_addr_i;
        cur_wdata <= cycle_wdata_i;
        cur_six <= fetch_six_i; // R6
        cur_noale <= ale_suppress_i; // R15
        cur_reads <= dec_read || dec_ack;
      end
    end
  end

  // pin outputs; reset floats the bus and strobes
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_or_mem_select_o <= `BCS_RST_SEL;
      io_or_mem_select_oe_o <= 1'b0; // R17
      cycle_status_bit_one_o <= 1'(`BCS_RST_STATUS >> 1);
      cycle_status_bit_zero_o <= 1'(`BCS_RST_STATUS);
      upper_address_lines_o <= `BCS_RST_BYTE;
      upper_address_lines_oe_o <= 1'b0; // R17
      low_address_data_bus_o <= `BCS_RST_BYTE;
      low_address_data_bus_oe_o <= 1'b0; // R17
      read_strobe_n_o <= `BCS_STROBE_OFF;
      read_strobe_oe_o <= 1'b0; // R17
      write_strobe_n_o <= `BCS_STROBE_OFF;
      write_strobe_oe_o <= 1'b0; // R17
      interrupt_ack_strobe_n_o <= `BCS_STROBE_OFF; // R17
      address_latch_strobe_o <= 1'b0; // R17
    end else begin
      io_or_mem_select_o <= next_sel;
      io_or_mem_select_oe_o <= !in_float; // R14 R18
      cycle_status_bit_one_o <= next_stat[1];
      cycle_status_bit_zero_o <= next_stat[0];
      upper_address_lines_o <= next_upper;
      upper_address_lines_oe_o <= !in_float; // R14 R18
      low_address_data_bus_o <= next_low;
      low_address_data_bus_oe_o <= next_low_oe;
      read_strobe_n_o <= next_rd_n;
      read_strobe_oe_o <= !in_float; // R14 R18
      write_strobe_n_o <= next_wr_n;
      write_strobe_oe_o <= !in_float; // R14 R18
      interrupt_ack_strobe_n_o <= next_ack_n;
      address_latch_strobe_o <= next_ale; // R15
    end
  end

  // core-side handshake, read data and power-down status
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cycle_taken_o <= 1'b0;
      read_data_valid_o <= 1'b0;
      read_data_o <= `BCS_RST_BYTE;
      hold_ack_o <= 1'b0;
      halted_o <= 1'b0;
      power_down_o <= 1'b0;
      halt_wake_o <= 1'b0;
    end else begin
      cycle_taken_o <= take_cycle;
      read_data_valid_o <= (state == bcs_pkg::ST_T3) && cur_reads;
      if ((state == bcs_pkg::ST_T3) && cur_reads) begin
        read_data_o <= low_address_data_bus_i;
      end
      hold_ack_o <= in_hold; // R22
      halted_o <= next_halted;
      power_down_o <= in_float; // R19
      halt_wake_o <= halt_leave; // R20
    end
  end

endmodule

// ==== testbench/bcs_bus_partner.sv ====
`timescale 1ns/1ps
module bcs_bus_partner (
  input wire logic clk_i,
  input wire logic ale_i,
  input wire logic [7:0] dut_bus_i,
  input wire logic dut_oe_i,
  input wire logic [7:0] upper_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ack_n_i,
  input wire logic [1:0] waits_i,
  output logic [7:0] bus_o,
  output logic ready_o,
  output logic [15:0] lat_o,
  output logic [7:0] wd_o
);
  logic [7:0] last = 8'h3c;
  logic [1:0] wc = 2'h0;
  initial lat_o = 16'h0000;
  initial wd_o = 8'h00;
  // wire level: released bus shows latched low address xor a5 under a read or ack strobe, else the inverse of its last value
  assign bus_o = dut_oe_i ? dut_bus_i : (!rd_n_i || !ack_n_i) ? lat_o[7:0] ^ 8'ha5 : ~last;
  assign ready_o = (wc == 2'h0);
  // latch address on strobe, capture writes, count wait states
  always @(posedge clk_i) begin
    last <= bus_o;
    if (ale_i) lat_o <= {upper_i, bus_o};
    if (!wr_n_i) wd_o <= bus_o;
    wc <= ale_i ? waits_i : (wc != 2'h0) ? wc - 2'h1 : wc;
  end
endmodule

// ==== testbench/bcs_sequencer_asserts.sv ====
`timescale 1ns/1ps
module bcs_sequencer_asserts (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cycle_taken_o,
  input wire logic address_latch_strobe_o,
  input wire logic low_address_data_bus_oe_o,
  input wire logic upper_address_lines_oe_o,
  input wire logic io_or_mem_select_o,
  input wire logic io_or_mem_select_oe_o,
  input wire logic cycle_status_bit_one_o,
  input wire logic cycle_status_bit_zero_o,
  input wire logic read_strobe_n_o,
  input wire logic read_strobe_oe_o,
  input wire logic write_strobe_n_o,
  input wire logic interrupt_ack_strobe_n_o,
  input wire logic read_data_valid_o,
  input wire logic hold_ack_o,
  input wire logic halted_o,
  input wire logic power_down_o,
  input wire logic halt_wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // strobe and status shorthands
  wire rd = !read_strobe_n_o;
  wire wr = !write_strobe_n_o;
  wire ack = !interrupt_ack_strobe_n_o;
  wire [2:0] st = {io_or_mem_select_o, cycle_status_bit_one_o, cycle_status_bit_zero_o};
  a_ale_first_t: assert property (address_latch_strobe_o |-> cycle_taken_o ##1 !address_latch_strobe_o)
    else $error("latch strobe outside first t state");
  a_t1_addr_out: assert property (address_latch_strobe_o |-> low_address_data_bus_oe_o)
    else $error("low bus not driven with latch strobe");
  a_strobe_late: assert property (cycle_taken_o |-> !rd && !wr && !ack)
    else $error("strobe active in first t state");
  a_min_three: assert property (cycle_taken_o |=> !cycle_taken_o ##1 !cycle_taken_o)
    else $error("machine cycle shorter than three t states");
  a_one_strobe: assert property ($onehot0({rd, wr, ack}))
    else $error("two strobes active together");
  a_read_code: assert property (rd |-> st[1] && !(st[2] && st[0]))
    else $error("read strobe with wrong status");
  a_write_code: assert property (wr |-> st[1:0] == 2'h1)
    else $error("write strobe with wrong status");
  a_ack_code: assert property (ack |-> st == 3'h7)
    else $error("acknowledge strobe with wrong status");
  a_halt_float: assert property (halted_o && !hold_ack_o |->
    st[1:0] == 2'h0 && !io_or_mem_select_oe_o && !read_strobe_oe_o)
    else $error("halt pins wrong");
  a_hold_float: assert property (hold_ack_o |-> !low_address_data_bus_oe_o &&
    !upper_address_lines_oe_o && !io_or_mem_select_oe_o && !read_strobe_oe_o &&
    !address_latch_strobe_o && !ack)
    else $error("hold pins wrong");
  a_valid_after: assert property (read_data_valid_o |-> $past(rd || ack))
    else $error("read data without transfer");
  a_power_flag: assert property (power_down_o == (halted_o || hold_ack_o))
    else $error("power down flag wrong");
  a_no_wake_hold: assert property (halt_wake_o |-> $past(halted_o && !hold_ack_o))
    else $error("wake outside halt");
endmodule

// ==== testbench/tb_bcs_sequencer.sv ====
`timescale 1ns/1ps
module tb_bcs_sequencer;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cycle_req_i = 1'b0, fetch_six_i = 1'b0, ale_suppress_i = 1'b0;
  logic halt_req_i = 1'b0, hold_i = 1'b0;
  bcs_pkg::bcs_cycle_t cycle_type_i = bcs_pkg::OPCODE_FETCH_CYCLE;
  logic [15:0] cycle_addr_i = 16'h0000;
  logic [7:0] cycle_wdata_i = 8'h00;
  logic [4:0] irq = 5'h00;
  logic [1:0] waits = 2'h0;
  wire [7:0] low_address_data_bus_o, upper_address_lines_o, read_data_o, bus, pwd;
  wire low_address_data_bus_oe_o, upper_address_lines_oe_o, io_or_mem_select_o;
  wire io_or_mem_select_oe_o, cycle_status_bit_one_o, cycle_status_bit_zero_o;
  wire read_strobe_n_o, read_strobe_oe_o, write_strobe_n_o, write_strobe_oe_o;
  wire interrupt_ack_strobe_n_o, address_latch_strobe_o, cycle_taken_o, read_data_valid_o;
  wire hold_ack_o, halted_o, power_down_o, halt_wake_o, rdy;
  wire [15:0] lat;
  wire [3:0] flags = {cycle_taken_o, halted_o, hold_ack_o, halt_wake_o};
  int num_errors = 0, n_tests = 0, cyc = 0, n;
  // expected status, strobe set {rd,wr,ack} and length per cycle kind
  logic [2:0] st_tab [8] = '{3'h3, 3'h2, 3'h1, 3'h6, 3'h5, 3'h7, 3'h2, 3'h7};
  logic [2:0] sk_tab [8] = '{3'h4, 3'h4, 3'h2, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
  int ln_tab [8] = '{4, 3, 3, 3, 3, 3, 3, 3};
  always #4 clk_i = ~clk_i;
  bcs_sequencer bcs_sequencer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cycle_req_i(cycle_req_i), .cycle_type_i(cycle_type_i), .cycle_addr_i(cycle_addr_i),
    .cycle_wdata_i(cycle_wdata_i), .fetch_six_i(fetch_six_i),
    .ale_suppress_i(ale_suppress_i), .halt_req_i(halt_req_i), .ready_i(rdy),
    .hold_i(hold_i), .nonmaskable_interrupt_i(irq[0]), .edge_restart_interrupt_i(irq[1]),
    .level_restart_interrupt_b_i(irq[2]), .level_restart_interrupt_a_i(irq[3]),
    .general_interrupt_request_i(irq[4]), .low_address_data_bus_i(bus),
    .low_address_data_bus_o(low_address_data_bus_o),
    .low_address_data_bus_oe_o(low_address_data_bus_oe_o),
    .upper_address_lines_o(upper_address_lines_o),
    .upper_address_lines_oe_o(upper_address_lines_oe_o),
    .io_or_mem_select_o(io_or_mem_select_o),
    .io_or_mem_select_oe_o(io_or_mem_select_oe_o),
    .cycle_status_bit_one_o(cycle_status_bit_one_o),
    .cycle_status_bit_zero_o(cycle_status_bit_zero_o),
    .read_strobe_n_o(read_strobe_n_o), .read_strobe_oe_o(read_strobe_oe_o),
    .write_strobe_n_o(write_strobe_n_o), .write_strobe_oe_o(write_strobe_oe_o),
    .interrupt_ack_strobe_n_o(interrupt_ack_strobe_n_o),
    .address_latch_strobe_o(address_latch_strobe_o), .cycle_taken_o(cycle_taken_o),
    .read_data_valid_o(read_data_valid_o), .read_data_o(read_data_o),
    .hold_ack_o(hold_ack_o), .halted_o(halted_o), .power_down_o(power_down_o),
    .halt_wake_o(halt_wake_o));
  bcs_bus_partner bcs_bus_partner_inst (.clk_i(clk_i), .ale_i(address_latch_strobe_o),
    .dut_bus_i(low_address_data_bus_o), .dut_oe_i(low_address_data_bus_oe_o),
    .upper_i(upper_address_lines_o), .rd_n_i(read_strobe_n_o), .wr_n_i(write_strobe_n_o),
    .ack_n_i(interrupt_ack_strobe_n_o), .waits_i(waits), .bus_o(bus), .ready_o(rdy),
    .lat_o(lat), .wd_o(pwd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for one of the flags to reach a level
  task automatic wflag(input int b, input logic lvl);
    for (n = 0; n < 40 && flags[b] !== lvl; n++) @(negedge clk_i);
  endtask
  // two back-to-back cycles of one kind; measure and check the first
  task automatic run_pair(input int k);
    logic [2:0] seen;
    logic v;
    logic [7:0] got;
    @(posedge clk_i);
    cycle_req_i <= 1'b1;
    cycle_type_i <= bcs_pkg::bcs_cycle_t'(k);
    cycle_addr_i <= 16'($urandom);
    cycle_wdata_i <= 8'($urandom);
    fetch_six_i <= 1'($urandom);
    ale_suppress_i <= (k == 6) ? 1'($urandom) : 1'b0;
    waits <= (k >= 1 && k <= 4) ? 2'($urandom % 3) : 2'h0;
    @(negedge clk_i);
    wflag(3, 1'b1);
    chk(address_latch_strobe_o, !ale_suppress_i);
    chk({io_or_mem_select_o, cycle_status_bit_one_o, cycle_status_bit_zero_o}, st_tab[k]);
    seen = 3'h0;
    v = 1'b0;
    got = 8'h00;
    for (n = 1; n < 40; n++) begin
      @(negedge clk_i);
      seen |= {!read_strobe_n_o, !write_strobe_n_o, !interrupt_ack_strobe_n_o};
      if (read_data_valid_o === 1'b1) begin
        v = 1'b1;
        got = read_data_o;
      end
      if (cycle_taken_o === 1'b1) break;
    end
    chk(16'(n), 16'(ln_tab[k] + ((k == 0 && fetch_six_i) ? 2 : 0) + waits));
    chk(seen, sk_tab[k]);
    chk(v, sk_tab[k][2] | sk_tab[k][0]);
    if (v && !ale_suppress_i) chk(got, cycle_addr_i[7:0] ^ 8'ha5);
    if (!ale_suppress_i) chk(lat, (k == 3 || k == 4) ? {2{cycle_addr_i[7:0]}} : cycle_addr_i);
    if (k == 2 || k == 4) chk(pwd, cycle_wdata_i);
    @(posedge clk_i);
    cycle_req_i <= 1'b0;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'hc2968ca6));
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int r = 0; r < 5; r++)
      for (int k = 0; k < 8; k++) run_pair(k);
    hold_i <= 1'b1;
    wflag(1, 1'b1);
    @(posedge clk_i);
    irq <= 5'h1f;
    repeat (4) @(negedge clk_i);
    chk({hold_ack_o, power_down_o, halted_o}, 3'h6);
    @(posedge clk_i);
    hold_i <= 1'b0;
    irq <= 5'h00;
    wflag(1, 1'b0);
    chk(power_down_o, 1'b0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      halt_req_i <= 1'b1;
      wflag(2, 1'b1);
      chk({cycle_status_bit_one_o, cycle_status_bit_zero_o, io_or_mem_select_oe_o}, 3'h0);
      @(posedge clk_i);
      halt_req_i <= 1'b0;
      hold_i <= 1'b1;
      wflag(1, 1'b1);
      @(posedge clk_i);
      hold_i <= 1'b0;
      wflag(1, 1'b0);
      chk({halted_o, power_down_o, halt_wake_o}, 3'h6);
      @(posedge clk_i);
      irq[i] <= 1'b1;
      wflag(0, 1'b1);
      chk({halt_wake_o, halted_o}, 2'h2);
      @(posedge clk_i);
      irq[i] <= 1'b0;
    end
    @(posedge clk_i);
    cycle_type_i <= bcs_pkg::MEMORY_WRITE_CYCLE;
    cycle_req_i <= 1'b1;
    wflag(3, 1'b1);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(negedge clk_i);
    chk({low_address_data_bus_oe_o, upper_address_lines_oe_o, io_or_mem_select_oe_o,
      read_strobe_oe_o, write_strobe_oe_o, address_latch_strobe_o,
      interrupt_ack_strobe_n_o}, 7'h01);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wflag(3, 1'b1);
    chk(cycle_taken_o, 1'b1);
    @(posedge clk_i);
    cycle_req_i <= 1'b0;
    run_pair(0);
    final_report();
  end
  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
endmodule
bind bcs_sequencer bcs_sequencer_asserts bcs_sequencer_asserts_inst (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .cycle_taken_o(cycle_taken_o),
  .address_latch_strobe_o(address_latch_strobe_o),
  .low_address_data_bus_oe_o(low_address_data_bus_oe_o),
  .upper_address_lines_oe_o(upper_address_lines_oe_o),
  .io_or_mem_select_o(io_or_mem_select_o),
  .io_or_mem_select_oe_o(io_or_mem_select_oe_o),
  .cycle_status_bit_one_o(cycle_status_bit_one_o),
  .cycle_status_bit_zero_o(cycle_status_bit_zero_o),
  .read_strobe_n_o(read_strobe_n_o), .read_strobe_oe_o(read_strobe_oe_o),
  .write_strobe_n_o(write_strobe_n_o),
  .interrupt_ack_strobe_n_o(interrupt_ack_strobe_n_o),
  .read_data_valid_o(read_data_valid_o), .hold_ack_o(hold_ack_o),
  .halted_o(halted_o), .power_down_o(power_down_o), .halt_wake_o(halt_wake_o));
